// >>> rtl/pchb_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : shared constants for the pfc / half-bridge sequencer
// Assumes : 250 MHz system clock
// Notes   : times in their own units, cycle counts derived from them
//////////////////////////////////////////////////////////////////////////////
package pchb_pkg;
    localparam int CLK_MHZ         = 250;
    localparam int WATCHDOG_US     = 180;
    localparam int BLANK_NS        = 110;
    localparam int DEAD_NS         = 785;
    // watchdog is a least time: whole cycles
    localparam int WATCHDOG_CYC    = WATCHDOG_US * CLK_MHZ;
    // blanking is a least time: round up
    localparam int BLANK_CYC       = (BLANK_NS * CLK_MHZ + 999) / 1000;
    // dead time is a least time: round up
    localparam int DEAD_CYC        = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int TIMER_W         = 16;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;
endpackage : pchb_pkg

// >>> rtl/pchb_bridge.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : half-bridge drive with divide-by-two and dead time
// Assumes : osc_tick_i is a one-cycle pulse per oscillator period
// Notes   : outputs registered
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module pchb_bridge #(
    parameter int DEAD_CYC = pchb_pkg::DEAD_CYC
) (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    input  wire logic run_i,
    input  wire logic osc_tick_i,
    input  wire logic boost_ok_i,
    output logic      bridge_low_drive_o,
    output logic      bridge_high_drive_o
);
    initial begin
        if (DEAD_CYC < 1 || DEAD_CYC > 65535)
        begin
            $error("DEAD_CYC out of range");
        end
    end

    typedef struct packed {
        logic        phase;
        logic [15:0] dead;
        logic        lo;
        logic        hi;
    } pchb_br_t;

    pchb_br_t st_reg;
    pchb_br_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (!run_i)
        begin
            st_next = '0;
        end
        else
        begin
            // divided clock toggles each oscillator period
            if (osc_tick_i)
            begin
                st_next.phase = ~st_reg.phase;
                st_next.dead  = 16'(DEAD_CYC);
            end
            else if (st_reg.dead != pchb_pkg::TIMER_ZERO)
            begin
                st_next.dead = st_reg.dead - 16'h0001;
            end
            // both off during dead time, else complementary halves
            st_next.lo = (st_next.dead == pchb_pkg::TIMER_ZERO) && !st_next.phase;
            st_next.hi = (st_next.dead == pchb_pkg::TIMER_ZERO) && st_next.phase
                         && boost_ok_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign bridge_low_drive_o  = st_reg.lo;
    assign bridge_high_drive_o = st_reg.hi;
endmodule : pchb_bridge
`default_nettype wire

// >>> rtl/pchb_core.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : pfc critical-conduction pulse control plus half-bridge sequencing
// Assumes : all comparator flags already synchronous to sys_clk_i
// Notes   : one clock; watchdog length is a parameter for simulation
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
// How it works
// - new pfc cycle starts when armed zero-cross detector sees fall below trigger
// - detector arms only when winding rises above arming level after turn-off
// - no pulse for watchdog interval starts a pulse anyway
// - watchdog clears at each pulse start and during feedback undervoltage
// - feedback undervoltage keeps the whole controller disabled
// - overvoltage suppresses pfc pulses until it clears
// - current limit ends the pulse, evaluated each cycle
// - current limit ignored during leading-edge blanking
// - half-bridge timing is oscillator divided by two
// - half-bridge fixed 50% duty, drives complementary
// - dead time with both drives off at every transition
// - each drive on a little under half the period
// - half-bridge stays off until first pfc pulse after enable
// - high drive only while boost supply is above its threshold
// - ramp peak ends pulse; ramp held discharged until next cycle
module pchb_core #(
    parameter int WATCHDOG_CYC = pchb_pkg::WATCHDOG_CYC,
    parameter int BLANK_CYC    = pchb_pkg::BLANK_CYC,
    parameter int DEAD_CYC     = pchb_pkg::DEAD_CYC
) (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    input  wire logic zcd_above_arm_i,
    input  wire logic zcd_above_trig_i,
    input  wire logic feedback_uv_i,
    input  wire logic feedback_ov_i,
    input  wire logic current_limit_i,
    input  wire logic ramp_peak_i,
    input  wire logic boost_ok_i,
    input  wire logic osc_tick_i,
    output logic      pfc_drive_o,
    output logic      ramp_discharge_o,
    output logic      bridge_low_drive_o,
    output logic      bridge_high_drive_o
);
    initial
    begin
        if (WATCHDOG_CYC < 2 || WATCHDOG_CYC > 65535)
        begin
            $error("WATCHDOG_CYC out of range");
        end
        if (BLANK_CYC < 1 || BLANK_CYC > 65535)
        begin
            $error("BLANK_CYC out of range");
        end
        if (DEAD_CYC < 1 || DEAD_CYC > 65535)
        begin
            $error("DEAD_CYC out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        PCHB_OFF  = 2'b00,
        PCHB_ON   = 2'b01,
        PCHB_WAIT = 2'b10
    } pchb_state_t;

    typedef struct packed {
        pchb_state_t state;
        logic        armed;
        logic        trig_prev;
        logic [15:0] wdog;
        logic [15:0] blank;
        logic        bridge_run;
        logic        drive;
        logic        discharge;
    } pchb_core_t;

    // idle image: drives off, ramp held discharged
    localparam pchb_core_t CORE_IDLE = '{
        state:      PCHB_OFF,
        armed:      1'b0,
        trig_prev:  1'b0,
        wdog:       pchb_pkg::TIMER_ZERO,
        blank:      pchb_pkg::TIMER_ZERO,
        bridge_run: 1'b0,
        drive:      1'b0,
        discharge:  1'b1
    };

    // last watchdog count before a forced start, first blanking count
    localparam logic [15:0] WDOG_TOP   = 16'(WATCHDOG_CYC - 1);
    localparam logic [15:0] BLANK_LOAD = 16'(BLANK_CYC - 1);

    pchb_core_t st_reg;
    pchb_core_t st_next;
    logic       start_pulse;
    logic       end_pulse;
    logic       zc_fall;
    logic       wdog_full;
    logic       blank_done;
    logic       bridge_run;

    ////////////////////////////////////////////////////////////////////////////
    // one step down toward zero, holding at zero
    function automatic logic [15:0] pchb_step_down(input logic [15:0] value);
        if (value == pchb_pkg::TIMER_ZERO)
        begin
            return value;
        end
        return value - 16'h0001;
    endfunction : pchb_step_down

    // one step up toward top, holding at top
    function automatic logic [15:0] pchb_step_up(input logic [15:0] value,
                                                input logic [15:0] top);
        if (value == top)
        begin
            return value;
        end
        return value + 16'h0001;
    endfunction : pchb_step_up

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next           = st_reg;
        st_next.trig_prev = zcd_above_trig_i;
        wdog_full         = (st_reg.wdog == WDOG_TOP);
        blank_done        = (st_reg.blank == pchb_pkg::TIMER_ZERO);
        zc_fall     = st_reg.armed && st_reg.trig_prev && !zcd_above_trig_i;
        start_pulse = 1'b0;
        end_pulse   = 1'b0;
        if (feedback_uv_i)
        begin
            st_next           = CORE_IDLE;
            st_next.trig_prev = zcd_above_trig_i;
        end
        else
        begin
            // watchdog counts enabled time, holds at its top
            st_next.wdog = pchb_step_up(st_reg.wdog, WDOG_TOP);
            case (st_reg.state)
                PCHB_OFF, PCHB_WAIT:
                begin
                    // arm only after rise at switch turn-off
                    if (zcd_above_arm_i)
                    begin
                        st_next.armed = 1'b1;
                    end
                    if (!feedback_ov_i && (zc_fall || wdog_full))
                    begin
                        start_pulse = 1'b1;
                    end
                end
                PCHB_ON:
                begin
                    // blanking runs down over the pulse
                    st_next.blank = pchb_step_down(st_reg.blank);
                    if (feedback_ov_i || ramp_peak_i ||
                        (current_limit_i && blank_done))
                    begin
                        end_pulse = 1'b1;
                    end
                end
                default:
                begin
                    st_next.state = PCHB_OFF;
                end
            endcase
            if (start_pulse)
            begin
                st_next.state      = PCHB_ON;
                st_next.wdog       = pchb_pkg::TIMER_ZERO;
                st_next.blank      = BLANK_LOAD;
                st_next.armed      = 1'b0;
                st_next.drive      = 1'b1;
                st_next.discharge  = 1'b0;
                st_next.bridge_run = 1'b1;
            end
            else if (end_pulse)
            begin
                st_next.state     = PCHB_WAIT;
                st_next.drive     = 1'b0;
                st_next.discharge = 1'b1;
            end
            else if (st_reg.state != PCHB_ON)
            begin
                st_next.discharge = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_reg <= CORE_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign pfc_drive_o      = st_reg.drive;
    assign ramp_discharge_o = st_reg.discharge;
    // undervoltage stops the bridge at the next edge, together with the pfc drive
    assign bridge_run       = st_reg.bridge_run && !feedback_uv_i;

    pchb_bridge #(
        .DEAD_CYC (DEAD_CYC)
    ) u_bridge (
        .sys_clk_i           (sys_clk_i),
        .reset_i             (reset_i),
        .run_i               (bridge_run),
        .osc_tick_i          (osc_tick_i),
        .boost_ok_i          (boost_ok_i),
        .bridge_low_drive_o  (bridge_low_drive_o),
        .bridge_high_drive_o (bridge_high_drive_o)
    );
endmodule : pchb_core
`default_nettype wire

// >>> dv/pchb_core_sva.sv
// Purpose: port assertions for pchb_core
// Assumes: comparator flags synchronous to sys_clk_i
// Notes: helper counters mirror pulse age, time since pulse start and dead time
`timescale 1ns/1ps
`default_nettype none
module pchb_core_sva #(
    parameter int WATCHDOG_CYC = pchb_pkg::WATCHDOG_CYC,
    parameter int BLANK_CYC    = pchb_pkg::BLANK_CYC,
    parameter int DEAD_CYC     = pchb_pkg::DEAD_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic zcd_above_arm_i,
    input wire logic zcd_above_trig_i,
    input wire logic feedback_uv_i,
    input wire logic feedback_ov_i,
    input wire logic current_limit_i,
    input wire logic ramp_peak_i,
    input wire logic boost_ok_i,
    input wire logic osc_tick_i,
    input wire logic pfc_drive_o,
    input wire logic ramp_discharge_o,
    input wire logic bridge_low_drive_o,
    input wire logic bridge_high_drive_o
);
    int   on_n, wd, dc;
    logic seen, drv_q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            on_n  <= 0;
            wd    <= 0;
            dc    <= 0;
            seen  <= 1'b0;
            drv_q <= 1'b0;
        end
        else
        begin
            on_n  <= pfc_drive_o ? on_n + 1 : 0;
            wd    <= (pfc_drive_o && !drv_q) ? 1 : (feedback_uv_i ? 0 : wd + 1);
            dc    <= osc_tick_i ? DEAD_CYC : (dc > 0 ? dc - 1 : 0);
            seen  <= !feedback_uv_i && (seen || pfc_drive_o);
            drv_q <= pfc_drive_o;
        end
    end
    sequence s_armed;
        !pfc_drive_o && !feedback_uv_i && zcd_above_arm_i;
    endsequence
    sequence s_fall;
        !pfc_drive_o && !feedback_uv_i && zcd_above_trig_i ##1
        !pfc_drive_o && !feedback_uv_i && !feedback_ov_i && !zcd_above_trig_i;
    endsequence
    chk_uv_off: assert property (feedback_uv_i |=> !pfc_drive_o
        && !bridge_low_drive_o && !bridge_high_drive_o) else $error("drive during uv");
    chk_ov_hold: assert property (feedback_ov_i |=> !pfc_drive_o)
        else $error("pfc drive during ov");
    chk_ilim_end: assert property (pfc_drive_o && current_limit_i
        && on_n >= BLANK_CYC - 1 |=> !pfc_drive_o) else $error("limit did not end pulse");
    chk_blank_hold: assert property (pfc_drive_o && on_n < BLANK_CYC - 1
        && !ramp_peak_i && !feedback_ov_i && !feedback_uv_i |=> pfc_drive_o)
        else $error("pulse cut early");
    chk_ramp_end: assert property (pfc_drive_o && ramp_peak_i |=> !pfc_drive_o)
        else $error("ramp peak did not end pulse");
    chk_disch_inv: assert property (ramp_discharge_o == !pfc_drive_o)
        else $error("discharge not held off-time");
    chk_zc_start: assert property (s_armed ##1 s_fall |=> pfc_drive_o)
        else $error("no start after zero cross");
    chk_wd_start: assert property (wd == WATCHDOG_CYC && !$past(feedback_ov_i)
        && !$past(feedback_uv_i) && !$past(pfc_drive_o) |-> pfc_drive_o) else $error("no restart");
    chk_dead_time: assert property (dc != 0
        |-> !bridge_low_drive_o && !bridge_high_drive_o) else $error("drive in dead time");
    chk_no_overlap: assert property (!(bridge_low_drive_o && bridge_high_drive_o))
        else $error("both bridge drives on");
    chk_boost_gate: assert property (!boost_ok_i |=> !bridge_high_drive_o)
        else $error("high drive without boost");
    chk_run_gate: assert property (!seen |-> !bridge_low_drive_o && !bridge_high_drive_o)
        else $error("bridge before first pulse");
endmodule : pchb_core_sva
bind pchb_core pchb_core_sva #(
    .WATCHDOG_CYC (WATCHDOG_CYC),
    .BLANK_CYC    (BLANK_CYC),
    .DEAD_CYC     (DEAD_CYC)
) i_sva (
    .sys_clk_i           (sys_clk_i),
    .reset_i             (reset_i),
    .zcd_above_arm_i     (zcd_above_arm_i),
    .zcd_above_trig_i    (zcd_above_trig_i),
    .feedback_uv_i       (feedback_uv_i),
    .feedback_ov_i       (feedback_ov_i),
    .current_limit_i     (current_limit_i),
    .ramp_peak_i         (ramp_peak_i),
    .boost_ok_i          (boost_ok_i),
    .osc_tick_i          (osc_tick_i),
    .pfc_drive_o         (pfc_drive_o),
    .ramp_discharge_o    (ramp_discharge_o),
    .bridge_low_drive_o  (bridge_low_drive_o),
    .bridge_high_drive_o (bridge_high_drive_o)
);
`default_nettype wire

// >>> dv/pchb_plant.sv
// Purpose: winding and current sense model
// Assumes: drive read each rising edge
// Notes: sense level rises in cycle ilim_i of on time
`timescale 1ns/1ps
`default_nettype none
module pchb_plant (
    input  wire logic       sys_clk_i,
    input  wire logic       pfc_drive_i,
    input  wire logic [7:0] ilim_i,
    input  wire logic [7:0] demag_i,
    output logic            arm_o,
    output logic            trig_o,
    output logic            cs_o
);
    int   on_n  = 0;
    int   off_n = 0;
    logic hit   = 1'b0;
    always @(posedge sys_clk_i)
    begin
        on_n  <= pfc_drive_i ? on_n + 1 : 0;
        off_n <= pfc_drive_i ? 0 : off_n + 1;
        hit   <= hit | pfc_drive_i;
    end
    // winding decays through arm level first, one cycle later trigger level
    assign arm_o  = hit && !pfc_drive_i && off_n < demag_i;
    assign trig_o = hit && !pfc_drive_i && off_n <= demag_i;
    assign cs_o   = pfc_drive_i && on_n + 1 >= ilim_i;
endmodule : pchb_plant
`default_nettype wire

// >>> dv/test_pfc_crm_and_half_bridge_sequencer.sv
// Purpose: self-checking bench for pchb_core
// Assumes: short watchdog and dead time parameters
// Notes: expected lengths worked out from the plant settings
`timescale 1ns/1ps
`default_nettype none
module test_pfc_crm_and_half_bridge_sequencer;
    localparam int WD = 200;
    localparam int BL = 28;
    localparam int DC = 5;
    localparam int PER = 40;
    logic sys_clk_i = 0, reset_i = 1, uv = 1, ov = 0, ramp = 0, boost = 1, tick = 0;
    logic arm, trig, cs, drv, dis, lo, hi;
    logic [7:0] ilim = 8'hFF, demag = 8'h04;
    int n_errors = 0, total_checks = 0, len, hl, hh;
    pchb_core #(.WATCHDOG_CYC(WD), .BLANK_CYC(BL), .DEAD_CYC(DC)) i_dut (.sys_clk_i,
        .reset_i, .zcd_above_arm_i(arm), .zcd_above_trig_i(trig), .feedback_uv_i(uv),
        .feedback_ov_i(ov), .current_limit_i(cs), .ramp_peak_i(ramp), .boost_ok_i(boost),
        .osc_tick_i(tick), .pfc_drive_o(drv), .ramp_discharge_o(dis),
        .bridge_low_drive_o(lo), .bridge_high_drive_o(hi));
    pchb_plant i_plant (.sys_clk_i, .pfc_drive_i(drv), .ilim_i(ilim), .demag_i(demag),
        .arm_o(arm), .trig_o(trig), .cs_o(cs));
    initial forever #2 sys_clk_i = ~sys_clk_i;
    initial forever
    begin
        repeat (PER - 1) @(posedge sys_clk_i);
        #1 tick = 1;
        @(posedge sys_clk_i);
        #1 tick = 0;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic wait_drv(input logic v, input int lim, output int n);
        n = 0;
        while (drv !== v)
        begin
            @(posedge sys_clk_i);
            #1 n++;
            if (n > lim)
            begin
                n_errors++;
                finish_test();
            end
        end
    endtask : wait_drv
    initial
    begin
        void'($urandom(32'h6F68));
        repeat (4) @(posedge sys_clk_i);
        #1 reset_i = 0;
        repeat (3) @(posedge sys_clk_i);
        #1 uv = 0;
        wait_drv(1, WD + 5, len);
        check(16'(len), 16'(WD));
        check(16'({lo, hi}), 16'h0000);
        for (int i = 0; i < 12; i++)
        begin
            ilim = 8'($urandom_range(1, 40));
            demag = 8'($urandom_range(2, 30));
            wait_drv(0, 300, len);
            check(16'(len), 16'((ilim > BL) ? ilim : BL));
            wait_drv(1, 300, len);
            check(16'(len), 16'(demag + 2));
        end
        for (int b = 1; b >= 0; b--)
        begin
            boost = (b == 1);
            @(posedge tick);
            hl = 0;
            hh = 0;
            repeat (8 * PER)
            begin
                @(posedge sys_clk_i);
                #1 hl += lo;
                hh += hi;
            end
            check(16'(hh), b ? 16'(4 * (PER - DC)) : 16'h0000);
            check(16'(hl), 16'(4 * (PER - DC)));
        end
        wait_drv(0, 300, len);
        ov = 1;
        hl = 0;
        repeat (WD + 50)
        begin
            @(posedge sys_clk_i);
            #1 hl += drv;
        end
        check(16'(hl), 16'h0000);
        ov = 0;
        wait_drv(1, 3, len);
        check(16'(len), 16'h0001);
        ramp = 1;
        wait_drv(0, 300, len);
        ramp = 0;
        check(16'(len), 16'h0001);
        wait_drv(1, 300, len);
        uv = 1;
        @(posedge sys_clk_i);
        #1 check(16'({drv, lo, hi}), 16'h0000);
        repeat (40) @(posedge sys_clk_i);
        #1 uv = 0;
        wait_drv(1, WD + 5, len);
        check(16'(len), 16'(WD));
        check(16'({lo, hi}), 16'h0000);
        finish_test();
    end
endmodule : test_pfc_crm_and_half_bridge_sequencer
`default_nettype wire
